// File: pkg/acsp_pkg.sv
// Constants, types and carriers shared by the converter control and port.
// Assumes one 40 MHz system clock; all pins are asynchronous to it.
//
// Overview of operation
// - Start fall holds, starts conversion, raises busy; 9 us or 27 us.
// - Channel code zero is the temperature sensor and the reset default.
// - Start already high when busy falls: stay powered (mode 1).
// - Start still low when busy falls: power down automatically (mode 2).
// - After automatic power-down, power up on the next start rising edge.
// - Slave port on serial clock only; select low writes, high reads.
// - Five-wire: select rising edge puts result msb on the data output.
// - Later result bits shift out on falling serial clock edges.
// - A read gives ten bits msb first; host may stop after eight.
// - Five-wire: output floats on chip select rising or select falling.
// - A write captures bits on the first eight rising clocks only.
// - Three-wire: select high drives msb at once; shifts from second fall.
// - Three-wire: shared pin returns to input on select falling edge.
package acsp_pkg;

    // Clock and conversion timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_ANALOG_NS = 9000;
    localparam int CONV_TEMP_NS = 27000;
    localparam int CONV_ANALOG_CYC =
        (CONV_ANALOG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_TEMP_CYC =
        (CONV_TEMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;

    // Data widths and field layout
    localparam int RES_W = 10;
    localparam int CTRL_W = 8;
    localparam int CHAN_W = 3;
    localparam int CHAN_LSB = 5;
    localparam logic [CHAN_W-1:0] CHAN_TEMP = 3'h0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
    localparam logic [3:0] WR_BITS = 4'h8;
    localparam logic [3:0] WR_LAST = 4'h7;

    // Conversion control states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONV  = 3'b010,
        ST_PDOWN = 3'b100
    } acsp_state_e;

    // Host pins as one carrier
    typedef struct packed {
        logic conv_n;
        logic sclk;
        logic rd_wr;
        logic cs_n;
        logic din;
    } acsp_pins_s;

    localparam acsp_pins_s PINS_IDLE = 5'h12;

    // Last count of a conversion on the given channel
    function automatic logic [CNT_W-1:0] conv_last(
        input logic [CHAN_W-1:0] chan
    );
        conv_last = (chan == CHAN_TEMP) ? CNT_W'(CONV_TEMP_CYC - 1)
                                        : CNT_W'(CONV_ANALOG_CYC - 1);
    endfunction

endpackage

// File: sim/acsp_host_model.sv
// Host model: drives the converter pins from sys_clk falling edges.
// Assumes one task runs at a time; sclk idles low, period 200 ns.
module acsp_host_model
    import acsp_pkg::*;
(
    // Clock and strap
    input wire logic sys_clk,
    input wire logic three_wire,
    // Device data out
    input wire logic dout,
    input wire logic dout_oe,
    // Host pins
    output logic conversion_start_n,
    output logic sclk,
    output logic rd_wr,
    output logic cs_n,
    output logic din
);
    timeunit 1ns;
    timeprecision 100ps;
    logic din_h = 1'b0;
    logic drv = 1'b0;
    logic pat = 1'b0;
    initial begin
        conversion_start_n = 1'b1;
        sclk = 1'b0;
        rd_wr = 1'b0;
        cs_n = 1'b1;
    end
    // A released data line toggles, so no stale value is mistaken for data
    always @(negedge sys_clk) pat <= ~pat;
    assign din = (three_wire && dout_oe) ? dout : (drv ? din_h : pat);
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Start pulse; in mode 2 held low past the end of conversion
    task automatic start_conv(input int low_cyc);
        conversion_start_n = 1'b0;
        wait_n(low_cyc);
        conversion_start_n = 1'b1;
    endtask
    // One sclk period; host samples the data pin after the rise
    task automatic pulse(input logic d, output logic q);
        din_h = d;
        wait_n(4);
        sclk = 1'b1;
        wait_n(1);
        q = three_wire ? din : dout;
        wait_n(3);
        sclk = 1'b0;
    endtask
    // Control write, select raised then lowered first
    task automatic write_byte(input logic [7:0] b, input int n);
        logic q;
        cs_n = 1'b0;
        rd_wr = 1'b1;
        wait_n(6);
        rd_wr = 1'b0;
        wait_n(6);
        drv = 1'b1;
        for (int i = 0; i < n; i++) pulse(i < 8 ? b[7-i] : ~b[0], q);
        drv = 1'b0;
        wait_n(6);
    endtask
    // Result read, select high throughout, fresh rise
    task automatic read_bits(input int n, input logic by_cs,
                             output logic [9:0] v, output logic oe_end);
        logic q;
        v = 10'h000;
        cs_n = 1'b0;
        rd_wr = 1'b1;
        wait_n(6);
        if (three_wire) pulse(1'b0, q);
        for (int i = 0; i < n; i++) begin
            pulse(1'b0, q);
            v = {v[8:0], q};
        end
        if (by_cs) cs_n = 1'b1;
        else rd_wr = 1'b0;
        wait_n(6);
        oe_end = dout_oe;
        rd_wr = 1'b0;
        cs_n = 1'b0;
        wait_n(4); // Quiet time before the next start
    endtask
endmodule

// File: sim/adc_conversion_serial_port_tb.sv
// Self-checking bench: random control bytes and codes, both modes and both variants in turn.
// Assumes acsp_top and the host model; 40 MHz clock, sclk 200 ns.
module adc_conversion_serial_port_tb
    import acsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic three_wire = 1'b0;
    logic [RES_W-1:0] conv_code = 10'h000;
    logic busy, hold, powered_down, dout, dout_oe;
    logic conversion_start_n, sclk, rd_wr, cs_n, din;
    logic [CHAN_W-1:0] channel;
    logic [CTRL_W-1:0] control_byte;
    int miscompares = 0;
    int tests_run = 0;
    // Clock of 25 ns
    always #12.5 sys_clk = ~sys_clk;
    acsp_top u_dut (.sys_clk(sys_clk), .rst(rst),
        .conversion_start_n(conversion_start_n), .sclk(sclk), .rd_wr(rd_wr),
        .cs_n(cs_n), .din(din), .three_wire(three_wire),
        .conv_code(conv_code), .busy(busy), .hold(hold),
        .powered_down(powered_down), .channel(channel),
        .control_byte(control_byte), .dout(dout), .dout_oe(dout_oe));
    acsp_host_model u_host (.sys_clk(sys_clk), .three_wire(three_wire),
        .dout(dout), .dout_oe(dout_oe),
        .conversion_start_n(conversion_start_n), .sclk(sclk),
        .rd_wr(rd_wr), .cs_n(cs_n), .din(din));
    function automatic int exp_len(input logic [2:0] ch);
        return (ch == 3'h0) ? 27000 / 25 : 9000 / 25;
    endfunction
    function automatic logic [9:0] exp_read(input logic [9:0] c, input int n);
        return (n == 10) ? c : {2'h0, c[9:2]};
    endfunction
    task automatic check(input string what, input logic [11:0] exp,
                         input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Start a conversion, time busy, look at the mode when busy falls
    task automatic convert(input int low, input logic m2, output int len);
        len = 0;
        fork
            u_host.start_conv(low);
            begin
                for (int i = 0; i < 10 && busy !== 1'b1; i++)
                    @(negedge sys_clk);
                check("hold", 12'(1), 12'(hold));
                while (busy === 1'b1 && len < 2000) begin
                    @(negedge sys_clk);
                    len++;
                end
                repeat (2) @(negedge sys_clk);
                check("pdown", 12'(m2), 12'(powered_down));
            end
        join
        repeat (8) @(negedge sys_clk);
        check("power_up", 12'(0), 12'(powered_down));
    endtask
    // Watchdog
    initial begin
        #(25ns * 40000);
        miscompares++;
        give_verdict();
    end
    // Main sequence
    initial begin
        logic [7:0] b;
        logic [9:0] v;
        logic [9:0] e;
        logic oe;
        int len, n;
        logic m2;
        void'($urandom(32'h6f892312));
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("channel", 12'(0), 12'(channel));
        check("control_byte", 12'(0), 12'(control_byte));
        check("busy", 12'(0), 12'(busy));
        for (int i = 0; i < 6; i++) begin
            three_wire = (i >= 3);
            b = 8'($urandom);
            if (i % 3 == 0) b[7:5] = 3'h0;
            u_host.write_byte(b, 8 + (i % 3) * 2);
            check("ctrl", 12'(b), 12'(control_byte));
            check("chan", 12'(b[7:5]), 12'(channel));
            u_host.write_byte(~b, 5);
            check("partial", 12'(b), 12'(control_byte));
            conv_code = 10'($urandom);
            m2 = 1'(i % 2);
            convert(m2 ? exp_len(b[7:5]) + 20 : 8, m2, len);
            check("busy_len", 12'(exp_len(b[7:5])), 12'(len));
            n = (i % 3 == 1) ? 8 : 10;
            u_host.read_bits(n, (i % 3 == 1) && i < 3, v, oe);
            e = exp_read(conv_code, n);
            check("result", 12'(e), 12'(v));
            check("release", 12'(0), 12'(oe));
            $display("test %0d done", i);
        end
        give_verdict();
    end
endmodule

// File: src/acsp_sync.sv
// Two-stage synchroniser and edge finder for the host pins.
// Assumes every pin is asynchronous to sys_clk; edges lag pins by 2-3 clocks.
module acsp_sync
    import acsp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Raw pins
    input wire acsp_pins_s pins_in,
    // Synchronised levels and edge pulses
    output acsp_pins_s lvl,
    output acsp_pins_s rise,
    output acsp_pins_s fall
);
    acsp_pins_s meta_r;
    acsp_pins_s sync_r;
    acsp_pins_s prev_r;

    // Metastability chain and history stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_r <= PINS_IDLE;
            sync_r <= PINS_IDLE;
            prev_r <= PINS_IDLE;
        end else begin
            meta_r <= pins_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edges from the second and third stages only
    assign lvl = sync_r;
    assign rise = acsp_pins_s'(sync_r & ~prev_r);
    assign fall = acsp_pins_s'(~sync_r & prev_r);
endmodule

// File: src/acsp_top.sv
// Conversion control, result register and serial host port.
// Assumes the converter core presents conv_code on sys_clk while busy.
module acsp_top
    import acsp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Host pins
    input wire logic conversion_start_n,
    input wire logic sclk,
    input wire logic rd_wr,
    input wire logic cs_n,
    input wire logic din,
    // Variant strap: high selects the three-wire port
    input wire logic three_wire,
    // Converter core
    input wire logic [RES_W-1:0] conv_code,
    // Status and control towards host and core
    output logic busy,
    output logic hold,
    output logic powered_down,
    output logic [CHAN_W-1:0] channel,
    output logic [CTRL_W-1:0] control_byte,
    // Serial data out with enable
    output logic dout,
    output logic dout_oe
);
    acsp_pins_s pins;
    acsp_pins_s lvl;
    acsp_pins_s rise;
    acsp_pins_s fall;
    acsp_state_e state_r;
    acsp_state_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] last_r;
    logic [RES_W-1:0] result_r;
    logic [RES_W-1:0] rd_sh_r;
    logic rd_skip_r;
    logic oe_r;
    logic [CTRL_W-1:0] wr_sh_r;
    logic [3:0] wr_cnt_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic tw_r;
    logic tw_meta_r;

    // Pin synchronisers
    assign pins = '{conv_n: conversion_start_n, sclk: sclk, rd_wr: rd_wr,
                    cs_n: cs_n, din: din};

    acsp_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pins_in(pins),
        .lvl(lvl),
        .rise(rise),
        .fall(fall)
    );

    // Variant strap pin passes two flops before any logic reads it
    always_ff @(posedge sys_clk) begin
        tw_meta_r <= three_wire;
        tw_r <= tw_meta_r;
    end

    // Conversion decode
    wire conv_done = (state_r == ST_CONV) && (cnt_r == last_r);
    wire conv_go = (state_r == ST_IDLE) && fall.conv_n;

    // Next state of conversion control
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (conv_go) begin
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done) begin
                    // Start level at busy fall picks the mode
                    state_nxt = lvl.conv_n ? ST_IDLE : ST_PDOWN;
                end
            end
            ST_PDOWN: begin
                if (rise.conv_n) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State, conversion timer and result register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_ZERO;
            last_r <= CNT_ZERO;
            result_r <= RESULT_RESET;
        end else begin
            state_r <= state_nxt;
            if (conv_go) begin
                cnt_r <= CNT_ZERO;
                last_r <= conv_last(channel);
            end else if (state_r == ST_CONV) begin
                cnt_r <= cnt_r + CNT_ONE;
            end
            if (conv_done) begin
                result_r <= conv_code;
            end
        end
    end

    assign busy = (state_r == ST_CONV);
    assign hold = (state_r == ST_CONV);
    assign powered_down = (state_r == ST_PDOWN);

    // Port selection and read framing
    wire port_en = tw_r || !lvl.cs_n;
    wire rd_start = rise.rd_wr && port_en;
    wire rd_stop = fall.rd_wr || (!tw_r && rise.cs_n);
    wire rd_shift = oe_r && fall.sclk;

    // Read shifter: msb on select rise, then one bit per falling clock; three-wire skips the first
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_sh_r <= RESULT_RESET;
            rd_skip_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (rd_start) begin
            rd_sh_r <= result_r;
            rd_skip_r <= tw_r;
            oe_r <= 1'b1;
        end else if (rd_stop) begin
            oe_r <= 1'b0;
        end else if (rd_shift) begin
            rd_skip_r <= 1'b0;
            if (!rd_skip_r) begin
                rd_sh_r <= {rd_sh_r[RES_W-2:0], 1'b0};
            end
        end
    end

    assign dout = rd_sh_r[RES_W-1];
    assign dout_oe = oe_r;

    // Write capture decode
    wire wr_take = !lvl.rd_wr && port_en && rise.sclk && (wr_cnt_r < WR_BITS);
    wire [CTRL_W-1:0] wr_word = {wr_sh_r[CTRL_W-2:0], lvl.din};

    // Write shifter: eight rising clocks, rearmed while select is high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_sh_r <= CTRL_RESET;
            wr_cnt_r <= 4'h0;
            ctrl_r <= CTRL_RESET;
        end else if (lvl.rd_wr) begin
            wr_cnt_r <= 4'h0;
        end else if (wr_take) begin
            wr_sh_r <= wr_word;
            wr_cnt_r <= wr_cnt_r + 4'h1;
            if (wr_cnt_r == WR_LAST) begin
                ctrl_r <= wr_word;
            end
        end
    end

    assign control_byte = ctrl_r;
    assign channel = ctrl_r[CHAN_LSB +: CHAN_W];

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic [CNT_W-1:0] busy_len_r;
    always_ff @(posedge sys_clk) begin
        if (rst || !busy) begin
            busy_len_r <= CNT_ZERO;
        end else begin
            busy_len_r <= busy_len_r + CNT_ONE;
        end
    end

    chk_busy_start: assert property (conv_go |=> busy && hold)
        else $error("busy did not rise on start");
    chk_busy_length: assert property (
        $fell(busy) |-> $past(busy_len_r) ==
            ((last_r == CNT_W'(CONV_TEMP_CYC - 1)) ?
             CNT_W'(CONV_TEMP_CYC - 1) : CNT_W'(CONV_ANALOG_CYC - 1)))
        else $error("conversion length wrong");
    chk_mode_one: assert property (
        conv_done && lvl.conv_n |=> !busy && !powered_down)
        else $error("mode 1 did not stay powered");
    chk_mode_two: assert property (
        conv_done && !lvl.conv_n |=> powered_down)
        else $error("mode 2 did not power down");
    chk_wake_rise: assert property (
        powered_down && !rise.conv_n |=> powered_down)
        else $error("left power-down wrongly");
    chk_wake_edge: assert property (
        powered_down && rise.conv_n |=> !powered_down ##1 !busy)
        else $error("no power-up on start rise");
    chk_result_load: assert property (
        conv_done |=> result_r == $past(conv_code) && !busy)
        else $error("result not loaded at busy fall");
    chk_read_msb: assert property (
        rd_start |=> dout_oe && dout == $past(result_r[RES_W-1]))
        else $error("msb not presented on read start");
    chk_oe_release: assert property (
        rd_stop && !rd_start |=> !dout_oe)
        else $error("data out not released");
    chk_skip_first: assert property (
        rd_shift && rd_skip_r && !rd_start && !rd_stop |=> $stable(rd_sh_r))
        else $error("three-wire shifted on first fall");
    chk_ctrl_apply: assert property (
        $changed(ctrl_r) |-> $past(wr_cnt_r) == WR_LAST && $past(wr_take))
        else $error("control byte applied early");
    chk_shift_step: assert property (
        rd_shift && !rd_skip_r && !rd_start && !rd_stop |=>
            dout == $past(rd_sh_r[RES_W-2]))
        else $error("read shifter skipped a bit");
    chk_late_ignore: assert property (
        !lvl.rd_wr && rise.sclk && wr_cnt_r == WR_BITS |=>
            $stable(ctrl_r) && $stable(wr_sh_r))
        else $error("write bit taken after the eighth");
endmodule
